// ===== hdl/sppsh_defs.vh
`ifndef SPPSH_DEFS_VH
`define SPPSH_DEFS_VH
// Pin indices within the shared-pin vector
`define SPPSH_PIN_RFS     0
`define SPPSH_PIN_RCK     1
`define SPPSH_PIN_TDAT    2
`define SPPSH_PIN_TFS     3
`define SPPSH_PIN_TCK     4
`define SPPSH_PIN_SCLK    5
`define SPPSH_PIN_MOSI    6
`define SPPSH_PIN_MISO    7
`define SPPSH_PIN_SS      8
`define SPPSH_PIN_TX0     9
`define SPPSH_PIN_RX0     10
`define SPPSH_NPINS       11
// Function select: 1 = serial function, 0 = general purpose
`define SPPSH_SEL_RESET   11'h7E0
`define SPPSH_DIR_RESET   11'h000
`define SPPSH_OUT_RESET   11'h000
// Synchroniser reset: select pin idles high, so no false slave select
`define SPPSH_SYNC_RESET  11'h100
`endif

// ===== hdl/sppsh_pin_share.v
// Operation
// - Receive frame-sync pin bidirectional, frame-sync or flag I/O for receiver
// - Receive clock pin carries receive bit clock, may clock both in sync mode
// - Transmit frame-sync pin is frame-sync or flag I/O, shareable when synchronous
// - Transmit clock pin carries transmit bit clock, may clock both sections
// - Sync transmit data pin outputs bits from the transmit shift register
// - After reset, sync serial pins on port C are general-purpose inputs
// - Port F pins individually programmable as GPIO when serial not selected
// - SPI clock driven as output in master, data clock input in slave
// - Master presents data half a clock before slave latching edge
// - Unselected slave holds its master-in/slave-out pin high impedance
// - Select pin arbitrates masters in master mode, enables slave in slave mode
// - After reset, SPI clock, master-in and select pins default to SPI function
// - Async channel 0 transmit pin defaults to async serial output after reset
// - Sync receive data pin passes input bits to the receive shift register
`timescale 1ns/100ps
`default_nettype none
`include "sppsh_defs.vh"
module sppsh_pin_share (
   // Clock and reset
   input  wire        SYS_CLK_I,
   input  wire        RST_B_I,
   // Function select and GPIO control (software side)
   input  wire [10:0] FUNC_SEL_WR_I,
   input  wire [10:0] FUNC_SEL_VAL_I,
   input  wire [10:0] GPIO_DIR_WR_I,
   input  wire [10:0] GPIO_DIR_VAL_I,
   input  wire [10:0] GPIO_OUT_WR_I,
   input  wire [10:0] GPIO_OUT_VAL_I,
   output wire [10:0] FUNC_SEL_O,
   output wire [10:0] GPIO_DIR_O,
   output wire [10:0] GPIO_IN_O,
   // Sync serial port peripheral side
   input  wire        SSP_RFS_OUT_I,
   input  wire        SSP_RFS_OE_I,
   input  wire        SSP_RCK_OUT_I,
   input  wire        SSP_RCK_OE_I,
   input  wire        SSP_TFS_OUT_I,
   input  wire        SSP_TFS_OE_I,
   input  wire        SSP_TCK_OUT_I,
   input  wire        SSP_TCK_OE_I,
   input  wire        SSP_TX_DATA_I,
   input  wire        SSP_TX_EN_I,
   output wire        SSP_RFS_IN_O,
   output wire        SSP_RCK_IN_O,
   output wire        SSP_TFS_IN_O,
   output wire        SSP_TCK_IN_O,
   output wire        SSP_RX_DATA_O,
   input  wire        SSP_RX_DATA_PIN_I,
   // SPI peripheral side
   input  wire        SPI_MASTER_I,
   input  wire        SPI_SCLK_OUT_I,
   input  wire        SPI_MOSI_OUT_I,
   input  wire        SPI_MISO_OUT_I,
   output wire        SPI_SCLK_IN_O,
   output wire        SPI_MOSI_IN_O,
   output wire        SPI_MISO_IN_O,
   output wire        SPI_SS_B_O,
   // Async channel 0 / second SPI side
   input  wire        ASC_TX_DATA_I,
   output wire        ASC_RX_DATA_O,
   input  wire        SPI2_SEL_I,
   input  wire        SPI2_MASTER_I,
   input  wire        SPI2_SCLK_OUT_I,
   input  wire        SPI2_MOSI_OUT_I,
   output wire        SPI2_SCLK_IN_O,
   output wire        SPI2_MOSI_IN_O,
   // Shared pins
   input  wire [10:0] PIN_IN_I,
   output wire [10:0] PIN_OUT_O,
   output wire [10:0] PIN_OE_O
);

   reg  [10:0] sel_q;
   reg  [10:0] sel_d;
   reg  [10:0] dir_q;
   reg  [10:0] dir_d;
   reg  [10:0] dout_q;
   reg  [10:0] dout_d;
   reg  [10:0] sync1_q;
   reg  [10:0] sync2_q;
   reg         srd1_q;
   reg         srd2_q;
   reg  [10:0] per_out_q;
   reg  [10:0] per_out_d;
   reg  [10:0] per_oe_q;
   reg  [10:0] per_oe_d;
   reg  [10:0] pin_out_q;
   reg  [10:0] pin_oe_q;
   wire        slave_sel;

   // Two-flop synchronisers on every pin input
   always @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         sync1_q <= `SPPSH_SYNC_RESET;
         sync2_q <= `SPPSH_SYNC_RESET;
         srd1_q  <= 1'b0;
         srd2_q  <= 1'b0;
      end else begin
         sync1_q <= PIN_IN_I;
         sync2_q <= sync1_q;
         srd1_q  <= SSP_RX_DATA_PIN_I;
         srd2_q  <= srd1_q;
      end
   end

   // Per-bit write strobes, one generate loop
   genvar g;
   generate
      for (g = 0; g < `SPPSH_NPINS; g = g + 1) begin : g_bit
         always @* begin
            sel_d[g]  = FUNC_SEL_WR_I[g] ? FUNC_SEL_VAL_I[g] : sel_q[g];
            dir_d[g]  = GPIO_DIR_WR_I[g] ? GPIO_DIR_VAL_I[g] : dir_q[g];
            dout_d[g] = GPIO_OUT_WR_I[g] ? GPIO_OUT_VAL_I[g] : dout_q[g];
         end
      end
   endgenerate

   always @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         sel_q  <= `SPPSH_SEL_RESET;
         dir_q  <= `SPPSH_DIR_RESET;
         dout_q <= `SPPSH_OUT_RESET;
      end else begin
         sel_q  <= sel_d;
         dir_q  <= dir_d;
         dout_q <= dout_d;
      end
   end

   // Slave enabled by active-low select from external master
   assign slave_sel = sel_q[`SPPSH_PIN_SS] & ~sync2_q[`SPPSH_PIN_SS];

   // Peripheral drive and enable per pin; timing of data against the
   // clock (half-cycle lead) is owned by the SPI shifter itself
   always @* begin
      per_out_d = `SPPSH_OUT_RESET;
      per_oe_d  = `SPPSH_DIR_RESET;
      per_out_d[`SPPSH_PIN_RFS]  = SSP_RFS_OUT_I;
      per_oe_d[`SPPSH_PIN_RFS]   = SSP_RFS_OE_I;
      per_out_d[`SPPSH_PIN_RCK]  = SSP_RCK_OUT_I;
      per_oe_d[`SPPSH_PIN_RCK]   = SSP_RCK_OE_I;
      per_out_d[`SPPSH_PIN_TDAT] = SSP_TX_DATA_I;
      per_oe_d[`SPPSH_PIN_TDAT]  = SSP_TX_EN_I;
      per_out_d[`SPPSH_PIN_TFS]  = SSP_TFS_OUT_I;
      per_oe_d[`SPPSH_PIN_TFS]   = SSP_TFS_OE_I;
      per_out_d[`SPPSH_PIN_TCK]  = SSP_TCK_OUT_I;
      per_oe_d[`SPPSH_PIN_TCK]   = SSP_TCK_OE_I;
      per_out_d[`SPPSH_PIN_SCLK] = SPI_SCLK_OUT_I;
      per_oe_d[`SPPSH_PIN_SCLK]  = SPI_MASTER_I;
      per_out_d[`SPPSH_PIN_MOSI] = SPI_MOSI_OUT_I;
      per_oe_d[`SPPSH_PIN_MOSI]  = SPI_MASTER_I;
      per_out_d[`SPPSH_PIN_MISO] = SPI_MISO_OUT_I;
      per_oe_d[`SPPSH_PIN_MISO]  = ~SPI_MASTER_I & slave_sel;
      // Select pin is only ever an input in serial mode
      if (SPI2_SEL_I) begin
         per_out_d[`SPPSH_PIN_TX0] = SPI2_SCLK_OUT_I;
         per_oe_d[`SPPSH_PIN_TX0]  = SPI2_MASTER_I;
         per_out_d[`SPPSH_PIN_RX0] = SPI2_MOSI_OUT_I;
         per_oe_d[`SPPSH_PIN_RX0]  = SPI2_MASTER_I;
      end else begin
         per_out_d[`SPPSH_PIN_TX0] = ASC_TX_DATA_I;
         per_oe_d[`SPPSH_PIN_TX0]  = 1'b1;
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         per_out_q <= `SPPSH_OUT_RESET;
         per_oe_q  <= `SPPSH_DIR_RESET;
      end else begin
         per_out_q <= per_out_d;
         per_oe_q  <= per_oe_d;
      end
   end

   // Final pin drive: one register stage, mux by function select
   always @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         pin_out_q <= `SPPSH_OUT_RESET;
         pin_oe_q  <= `SPPSH_DIR_RESET;
      end else begin
         pin_out_q <= (sel_q & per_out_q) | (~sel_q & dout_q);
         pin_oe_q  <= (sel_q & per_oe_q) | (~sel_q & dir_q);
      end
   end

   assign PIN_OUT_O  = pin_out_q;
   assign PIN_OE_O   = pin_oe_q;
   assign FUNC_SEL_O = sel_q;
   assign GPIO_DIR_O = dir_q;
   assign GPIO_IN_O  = sync2_q;

   // Peripheral inputs gated to idle when pin is in GPIO mode
   assign SSP_RFS_IN_O   = sel_q[`SPPSH_PIN_RFS] & sync2_q[`SPPSH_PIN_RFS];
   assign SSP_RCK_IN_O   = sel_q[`SPPSH_PIN_RCK] & sync2_q[`SPPSH_PIN_RCK];
   assign SSP_TFS_IN_O   = sel_q[`SPPSH_PIN_TFS] & sync2_q[`SPPSH_PIN_TFS];
   assign SSP_TCK_IN_O   = sel_q[`SPPSH_PIN_TCK] & sync2_q[`SPPSH_PIN_TCK];
   assign SSP_RX_DATA_O  = srd2_q;
   assign SPI_SCLK_IN_O  = sel_q[`SPPSH_PIN_SCLK] & sync2_q[`SPPSH_PIN_SCLK];
   assign SPI_MOSI_IN_O  = sel_q[`SPPSH_PIN_MOSI] & sync2_q[`SPPSH_PIN_MOSI];
   assign SPI_MISO_IN_O  = sel_q[`SPPSH_PIN_MISO] & sync2_q[`SPPSH_PIN_MISO];
   assign SPI_SS_B_O     = ~slave_sel;
   assign ASC_RX_DATA_O  = sel_q[`SPPSH_PIN_RX0] & sync2_q[`SPPSH_PIN_RX0];
   assign SPI2_SCLK_IN_O = sel_q[`SPPSH_PIN_TX0] & sync2_q[`SPPSH_PIN_TX0];
   assign SPI2_MOSI_IN_O = sel_q[`SPPSH_PIN_RX0] & sync2_q[`SPPSH_PIN_RX0];

endmodule
`default_nettype wire

// ===== sim/sppsh_pin_share_props.sv
`timescale 1ns/100ps
`default_nettype none
module sppsh_pin_share_props (
   // Clock, reset and controls
   input wire        SYS_CLK_I,
   input wire        RST_B_I,
   input wire        SPI_MASTER_I,
   input wire        SPI_SCLK_OUT_I,
   input wire        SPI2_SEL_I,
   input wire [10:0] FUNC_SEL_WR_I,
   input wire [10:0] FUNC_SEL_VAL_I,
   input wire [10:0] GPIO_DIR_WR_I,
   input wire [10:0] GPIO_DIR_VAL_I,
   input wire [10:0] PIN_IN_I,
   // Observed outputs
   input wire        SPI_SS_B_O,
   input wire [10:0] FUNC_SEL_O,
   input wire [10:0] GPIO_DIR_O,
   input wire [10:0] PIN_OUT_O,
   input wire [10:0] PIN_OE_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);
   property p_sel_upd;
      1 |=> FUNC_SEL_O == ($past(FUNC_SEL_O) & ~$past(FUNC_SEL_WR_I)
         | $past(FUNC_SEL_VAL_I) & $past(FUNC_SEL_WR_I));
   endproperty
   a_sel_upd: assert property (p_sel_upd) else $error("sel");
   property p_dir_upd;
      1 |=> GPIO_DIR_O == ($past(GPIO_DIR_O) & ~$past(GPIO_DIR_WR_I)
         | $past(GPIO_DIR_VAL_I) & $past(GPIO_DIR_WR_I));
   endproperty
   a_dir_upd: assert property (p_dir_upd) else $error("dir");
   property p_rst_dflt;
      $rose(RST_B_I) |-> FUNC_SEL_O == 11'h7E0 && GPIO_DIR_O == 11'h000;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) else $error("rst");
   property p_tx0_dflt;
      $rose(RST_B_I) && !SPI2_SEL_I |-> ##[2:3] PIN_OE_O[9];
   endproperty
   a_tx0_dflt: assert property (p_tx0_dflt) else $error("tx0");
   // Two samples so the one-stage lag behind a select change is excluded
   property p_oe_gpio;
      FUNC_SEL_O[4:0] == 5'h00 [*2] |-> PIN_OE_O[4:0] == $past(GPIO_DIR_O[4:0]);
   endproperty
   a_oe_gpio: assert property (p_oe_gpio) else $error("oe");
   property p_sclk_mst;
      (FUNC_SEL_O[5] && SPI_MASTER_I) [*3]
         |-> PIN_OE_O[5] && PIN_OUT_O[5] == $past(SPI_SCLK_OUT_I, 2);
   endproperty
   a_sclk_mst: assert property (p_sclk_mst) else $error("sclk");
   property p_miso_hiz;
      (FUNC_SEL_O[7] && !SPI_MASTER_I && PIN_IN_I[8]) [*5] |-> !PIN_OE_O[7];
   endproperty
   a_miso_hiz: assert property (p_miso_hiz) else $error("miso");
   property p_ss_sel;
      (FUNC_SEL_O[8] && !PIN_IN_I[8]) [*4] |-> !SPI_SS_B_O;
   endproperty
   a_ss_sel: assert property (p_ss_sel) else $error("select");
endmodule
bind sppsh_pin_share sppsh_pin_share_props chk_u (.*);
`default_nettype wire

// ===== sim/sppsh_ext_dev.sv
`timescale 1ns/100ps
`default_nettype none
module sppsh_ext_dev (
   input  wire        clk_i,
   input  wire        frame_i,
   input  wire [10:0] drv_i,
   input  wire [10:0] dut_out_i,
   input  wire [10:0] dut_oe_i,
   output wire [10:0] pin_o
);
   logic [3:0]  cnt_q;
   logic [10:0] ext;
   // Bit clock stands still outside a frame
   always @(posedge clk_i) cnt_q <= frame_i ? cnt_q + 4'h1 : 4'h0;
   // Data moves as the clock falls, half a period ahead of latching
   assign ext = frame_i ? {drv_i[10:9], 1'h0, drv_i[7], cnt_q[3], cnt_q[2],
      drv_i[4:0]} : drv_i;
   assign pin_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & ext);
endmodule
`default_nettype wire

// ===== sim/serial_port_pin_sharing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_pin_sharing_tb;
   logic SYS_CLK_I = '0, RST_B_I = '0, frame = '0, SSP_RFS_OUT_I = '0;
   logic SSP_RFS_OE_I = '0, SSP_RCK_OUT_I = '0, SSP_RCK_OE_I = '0;
   logic SSP_TFS_OUT_I = '0, SSP_TFS_OE_I = '0, SSP_TCK_OUT_I = '0;
   logic SSP_TCK_OE_I = '0, SSP_TX_DATA_I = '0, SSP_TX_EN_I = '0;
   logic SSP_RX_DATA_PIN_I = '0, SPI_MASTER_I = '0, SPI_SCLK_OUT_I = '0;
   logic SPI_MOSI_OUT_I = '0, SPI_MISO_OUT_I = '0, ASC_TX_DATA_I = '0;
   logic SPI2_SEL_I = '0, SPI2_MASTER_I = '0, SPI2_SCLK_OUT_I = '0;
   logic SPI2_MOSI_OUT_I = '0, SSP_RFS_IN_O, SSP_RCK_IN_O, SSP_TFS_IN_O;
   logic SSP_TCK_IN_O, SSP_RX_DATA_O, SPI_SCLK_IN_O, SPI_MOSI_IN_O;
   logic SPI_MISO_IN_O, SPI_SS_B_O, ASC_RX_DATA_O, SPI2_SCLK_IN_O;
   logic SPI2_MOSI_IN_O;
   logic [10:0] FUNC_SEL_O, GPIO_DIR_O, GPIO_IN_O, PIN_IN_I, PIN_OUT_O;
   logic [10:0] PIN_OE_O, drv = 11'h1DE;
   logic [10:0] ws [3] = '{default: '0};
   logic [10:0] vs [3] = '{default: '0};
   int          errors = 0, total_checks = 0, n;
   sppsh_pin_share dut_u (.FUNC_SEL_WR_I(ws[0]), .FUNC_SEL_VAL_I(vs[0]),
      .GPIO_DIR_WR_I(ws[1]), .GPIO_DIR_VAL_I(vs[1]),
      .GPIO_OUT_WR_I(ws[2]), .GPIO_OUT_VAL_I(vs[2]), .*);
   sppsh_ext_dev ext_u (.clk_i(SYS_CLK_I), .frame_i(frame), .drv_i(drv),
      .dut_out_i(PIN_OUT_O), .dut_oe_i(PIN_OE_O), .pin_o(PIN_IN_I));
   always #2.5 SYS_CLK_I = ~SYS_CLK_I;
   task chk(input string nm, input logic [10:0] e, input logic [10:0] s);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", nm, e, s);
      end
   endtask
   task cyc(input int c);
      repeat (c) @(negedge SYS_CLK_I);
   endtask
   task wr(input int k, input logic [10:0] m, input logic [10:0] v);
      ws[k] = m;
      vs[k] = v;
      cyc(1);
      ws[k] = 11'h000;
   endtask
   task end_of_test;
      if (errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task t_reset;
      cyc(3);
      chk("sel", 11'h7E0, FUNC_SEL_O);
      chk("dir", 11'h000, GPIO_DIR_O);
      chk("oe", 11'h200, PIN_OE_O);
   endtask
   task t_gpio;
      wr(0, 11'h7FF, 11'h000);
      wr(2, 11'h7FF, 11'h5A5);
      wr(1, 11'h5F0, 11'h7FF);
      cyc(1);
      chk("gpio oe", 11'h5F0, PIN_OE_O);
      chk("gpio out", 11'h5A0, PIN_OUT_O & PIN_OE_O);
      cyc(3);
      chk("gpio in", 11'h5AE, GPIO_IN_O);
   endtask
   task t_ssp;
      {SSP_TX_EN_I, SSP_TX_DATA_I, SSP_TCK_OE_I, SSP_TCK_OUT_I, SSP_TFS_OE_I,
         SSP_TFS_OUT_I, SSP_RCK_OE_I, SSP_RCK_OUT_I, SSP_RFS_OE_I,
         SSP_RFS_OUT_I} = 10'h363;
      SSP_RX_DATA_PIN_I = 1'h1;
      wr(0, 11'h01F, 11'h01F);
      cyc(4);
      chk("ssp oe", 11'h00D, PIN_OE_O & 11'h01F);
      chk("ssp out", 11'h005, PIN_OUT_O & PIN_OE_O & 11'h01F);
      chk("ssp in", 11'h01B, {6'h00, SSP_RFS_IN_O, SSP_RCK_IN_O,
         SSP_TFS_IN_O, SSP_TCK_IN_O, SSP_RX_DATA_O});
   endtask
   task t_spi;
      wr(0, 11'h1E0, 11'h1E0);
      SPI_MASTER_I = 1'h1;
      SPI_SCLK_OUT_I = 1'h1;
      cyc(3);
      chk("sclk mst", 11'h003, {9'h000, PIN_OE_O[5], PIN_OUT_O[5]});
      SPI_MASTER_I = 1'h0;
      SPI_MISO_OUT_I = 1'h1;
      frame = 1'h1;
      n = 0;
      while (PIN_OE_O[7] !== 1'h1 && n < 8) begin
         cyc(1);
         n++;
      end
      if (n == 8) begin
         errors++;
         end_of_test();
      end
      chk("slave", 11'h003, {7'h00, SPI_SS_B_O, PIN_OE_O[5], PIN_OE_O[7],
         PIN_OUT_O[7]});
      frame = 1'h0;
      cyc(6);
      chk("miso off", 11'h000, {10'h000, PIN_OE_O[7]});
      chk("spi in", 11'h006, {7'h00, SPI_SCLK_IN_O, SPI_MOSI_IN_O,
         SPI_MISO_IN_O, ASC_RX_DATA_O});
   endtask
   task t_tx0;
      wr(0, 11'h600, 11'h600);
      ASC_TX_DATA_I = 1'h1;
      cyc(3);
      chk("tx0", 11'h003, {9'h000, PIN_OE_O[9], PIN_OUT_O[9]});
      SPI2_SEL_I = 1'h1;
      SPI2_MASTER_I = 1'h1;
      cyc(3);
      chk("spi2 clk", 11'h002, {9'h000, PIN_OE_O[9], PIN_OUT_O[9]});
   endtask
   initial begin
      cyc(6);
      RST_B_I = 1'h1;
      t_reset();
      t_gpio();
      t_ssp();
      t_spi();
      t_tx0();
      end_of_test();
   end
endmodule
`default_nettype wire
